// File: verilog/plpm_top.sv
// Link and device power state manager of the upstream port
// Behaviour
// - L0s entry off after reset; allowed only when the enable field is set.
// - With L0s enabled, transmitter enters L0s after more than 6 us idle.
// - A waiting TLP or DLLP starts the exit from L0s.
// - Nothing is transmitted while the transmitter sits in L0s.
// - Transmit L0s is independent of the partner's transmit state.
// - Active-state logic never enters L1; only D3hot leads to L1.
// - Writing D3hot to the power state field starts L1 entry.
// - No traffic in L1; either side may start the exit.
// - Return from D3hot to D0 sets the no-soft-reset status bit.
// - Reset gives D0 uninitialized; any space or master enable gives D0 active.
// - Configuration writes are still taken in D3hot.
// - Only D0 and D3hot are accepted; D1 and D2 writes are dropped.
// - PME_Turn_Off is answered with PME_TO_Ack before L2/L3 Ready entry.
// - No traffic once the link is in L2/L3 Ready.
// - A PM_PME message first brings the link back to L0.
// - The PME input is sampled once every 100 us.
// - PM_PME goes out as a posted message routed to the root complex.
// - No PME from D3cold, no beacon and no wake pin.
// - D3hot in L0 or L1 keeps PCI clocks, no bus reset, PME only.
// - In L2/L3 Ready the PCI side is down and PME is ignored.
// - Power-on reset returns to D0 uninitialized with all context lost.
// - All logic runs on the single core clock.
`timescale 1ns/10ps
module plpm_top
  import plpm_pkg::*;
#(
  parameter int PME_SAMPLE_CYCLES = PME_SAMPLE_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CFG_L0S_ENABLE,
  input wire logic CFG_PWR_WR,
  input wire logic [1:0] CFG_PWR_DATA,
  input wire logic CFG_MEM_EN,
  input wire logic CFG_IO_EN,
  input wire logic CFG_BM_EN,
  input wire logic TX_PENDING,
  input wire logic TX_SENT,
  input wire logic TX_MSG_DONE,
  input wire logic RX_TURN_OFF,
  input wire logic [2:0] PHY_CUR_STATE,
  input wire logic PCI_PME_N,
  output logic TX_ALLOW,
  output logic TX_MSG_REQ,
  output logic [7:0] TX_MSG_CODE,
  output logic [2:0] TX_MSG_ROUTE,
  output logic TX_MSG_POSTED,
  output logic [2:0] PHY_REQ_STATE,
  output logic [1:0] PWR_STATE_FIELD,
  output logic D0_ACTIVE,
  output logic NO_SOFT_RESET,
  output logic PCI_CLK_RUN,
  output logic PCI_BUS_RESET_OUT_N,
  output logic PCI_XACT_ALLOW
);

  localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = IDLE_CNT_W'(L0S_IDLE_CYC);

  // Physical layer request that belongs to each link state
  function automatic plpm_phy_t phy_target(input plpm_link_t st);
    case (st)
      LK_L0S: phy_target = PHY_L0S;
      LK_L1_ENTER, LK_L1: phy_target = PHY_L1;
      LK_L23_ENTER, LK_L23: phy_target = PHY_L23;
      default: phy_target = PHY_L0;
    endcase
  endfunction : phy_target

  plpm_pme_if pme_if ();
  plpm_link_t link_q;
  plpm_link_t link_d;
  plpm_phy_t phy_req_q;
  plpm_phy_t phy_req_d;
  logic [IDLE_CNT_W-1:0] idle_cnt_q;
  logic [IDLE_CNT_W-1:0] idle_cnt_d;
  logic tx_allow_q;
  logic tx_allow_d;
  logic clk_run_q;
  logic clk_run_d;
  logic bus_rst_n_q;
  logic bus_rst_n_d;
  logic xact_q;
  logic xact_d;
  plpm_dstate_t dstate_q;
  plpm_dstate_t dstate_d;
  logic [1:0] pwr_field_q;
  logic [1:0] pwr_field_d;
  logic nsr_q;
  logic nsr_d;
  logic l1_go_q;
  logic l1_go_d;
  logic d0_act_q;
  logic d0_act_d;
  logic ack_pend_q;
  logic ack_pend_d;
  logic ack_sent_q;
  logic ack_sent_d;
  logic pme_pend_q;
  logic pme_pend_d;
  logic msg_req_q;
  logic msg_req_d;
  logic [7:0] msg_code_q;
  logic [7:0] msg_code_d;
  logic idle_done;
  logic busy;
  logic pwr_wr_ok;

  // sampled PME input, interval shortened by parameter in simulation
  plpm_pme_sampler #(.SAMPLE_CYCLES(PME_SAMPLE_CYCLES)) u_sampler (
    .clk(CORE_CLK),
    .rst(RST),
    .pme_pin_n(PCI_PME_N),
    .pme(pme_if)
  );

  // PME input muted from L2/L3 Ready entry onward
  assign pme_if.ignore = (link_q == LK_L23_ENTER) || (link_q == LK_L23);

  always_comb begin
    idle_done = (idle_cnt_q >= IDLE_LIMIT) && !TX_SENT;
    busy = TX_PENDING || msg_req_q || ack_pend_q || pme_pend_q;
    link_d = link_q;
    idle_cnt_d = idle_cnt_q;
    // restart on any sent or queued packet
    if (link_q != LK_L0 || busy || TX_SENT) begin
      idle_cnt_d = '0;
    end else if (!idle_done) begin
      idle_cnt_d = idle_cnt_q + 1'b1;
    end
    case (link_q)
      LK_L0: begin
        // acknowledge sent, stage for power removal
        if (ack_sent_q && !busy) begin
          link_d = LK_L23_ENTER;
        // D3hot drives L1 entry once the queue is drained
        end else if (dstate_q == DS_D3HOT && !busy && (l1_go_q || idle_done)) begin
          link_d = LK_L1_ENTER;
        // active-state entry only into L0s and only when enabled
        end else if (dstate_q != DS_D3HOT && CFG_L0S_ENABLE && idle_done && !busy) begin
          link_d = LK_L0S;
        end
      end
      LK_L0S: begin
        // pending traffic or a policy change wakes the transmitter
        if (busy || !CFG_L0S_ENABLE || dstate_q == DS_D3HOT) begin
          link_d = LK_L0S_EXIT;
        end
      end
      // only our transmit state is tracked; the receive side is left alone
      LK_L0S_EXIT, LK_L1_EXIT: begin
        if (PHY_CUR_STATE == PHY_L0) begin
          link_d = LK_L0;
        end
      end
      LK_L1_ENTER: begin
        if (PHY_CUR_STATE == PHY_L1) begin
          link_d = LK_L1;
        end
      end
      LK_L1: begin
        // upstream exit is followed, local demand starts our own exit
        if (PHY_CUR_STATE == PHY_L0) begin
          link_d = LK_L0;
        // a queued message forces the return to L0
        end else if (dstate_q != DS_D3HOT || busy) begin
          link_d = LK_L1_EXIT;
        end
      end
      LK_L23_ENTER: begin
        if (PHY_CUR_STATE == PHY_L23) begin
          link_d = LK_L23;
        end
      end
      LK_L23: link_d = LK_L23;
      default: link_d = LK_L0;
    endcase
    phy_req_d = phy_target(link_d);
    // transmit only while the link is fully up
    tx_allow_d = (link_d == LK_L0);
    // PCI side stays clocked and out of reset until L2/L3 Ready
    clk_run_d = (link_d != LK_L23);
    bus_rst_n_d = (link_d != LK_L23);
    xact_d = (dstate_d != DS_D3HOT) && (link_d != LK_L23) && (link_d != LK_L23_ENTER);
  end

  // single clock, power-on reset clears all context
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      link_q <= LK_L0;
      phy_req_q <= PHY_L0;
      idle_cnt_q <= '0;
      tx_allow_q <= 1'b0;
      clk_run_q <= 1'b1;
      bus_rst_n_q <= 1'b0;
      xact_q <= 1'b0;
    end else begin
      link_q <= link_d;
      phy_req_q <= phy_req_d;
      idle_cnt_q <= idle_cnt_d;
      tx_allow_q <= tx_allow_d;
      clk_run_q <= clk_run_d;
      bus_rst_n_q <= bus_rst_n_d;
      xact_q <= xact_d;
    end
  end

  always_comb begin
    dstate_d = dstate_q;
    pwr_field_d = pwr_field_q;
    nsr_d = nsr_q;
    l1_go_d = l1_go_q;
    // D1 and D2 writes leave the field untouched
    pwr_wr_ok = CFG_PWR_WR && (CFG_PWR_DATA == PWR_FIELD_D0 || CFG_PWR_DATA == PWR_FIELD_D3HOT);
    if (link_q == LK_L1) begin
      l1_go_d = 1'b0;
    end
    // configuration writes are honoured in every state
    if (pwr_wr_ok) begin
      pwr_field_d = CFG_PWR_DATA;
    end
    if (pwr_wr_ok && dstate_q == DS_D3HOT && CFG_PWR_DATA == PWR_FIELD_D0) begin
      // back to D0 without internal reset
      dstate_d = DS_D0_UNINIT;
      nsr_d = 1'b1;
    end else if (pwr_wr_ok && dstate_q != DS_D3HOT && CFG_PWR_DATA == PWR_FIELD_D3HOT) begin
      // request L1 as soon as the link is free
      dstate_d = DS_D3HOT;
      l1_go_d = 1'b1;
    end else if (dstate_q == DS_D0_UNINIT && (CFG_MEM_EN || CFG_IO_EN || CFG_BM_EN)) begin
      dstate_d = DS_D0_ACTIVE;
    end
    d0_act_d = (dstate_d == DS_D0_ACTIVE);
  end

  // reset always lands in D0 uninitialized
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dstate_q <= DS_D0_UNINIT;
      pwr_field_q <= PWR_FIELD_RST;
      nsr_q <= 1'b0;
      l1_go_q <= 1'b0;
      d0_act_q <= 1'b0;
    end else begin
      dstate_q <= dstate_d;
      pwr_field_q <= pwr_field_d;
      nsr_q <= nsr_d;
      l1_go_q <= l1_go_d;
      d0_act_q <= d0_act_d;
    end
  end

  always_comb begin
    ack_pend_d = ack_pend_q;
    ack_sent_d = ack_sent_q;
    pme_pend_d = pme_pend_q;
    msg_req_d = msg_req_q;
    msg_code_d = msg_code_q;
    if (msg_req_q && TX_MSG_DONE) begin
      msg_req_d = 1'b0;
      if (msg_code_q == MSG_CODE_TO_ACK) begin
        ack_sent_d = 1'b1;
      end
    // a message is only launched with the link in L0
    end else if (!msg_req_q && link_q == LK_L0 && (ack_pend_q || pme_pend_q)) begin
      msg_req_d = 1'b1;
      // Acknowledge first: power may be pulled soon after the broadcast
      if (ack_pend_q) begin
        msg_code_d = MSG_CODE_TO_ACK;
        ack_pend_d = 1'b0;
      end else begin
        msg_code_d = MSG_CODE_PME;
        pme_pend_d = 1'b0;
      end
    end
    // New events are applied last so that a set beats a same-cycle clear
    // turn-off broadcast queues the acknowledge
    if (RX_TURN_OFF && !ack_sent_q) begin
      ack_pend_d = 1'b1;
    end
    // PME requests come only from the powered PCI side
    if (pme_if.new_pme) begin
      pme_pend_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ack_pend_q <= 1'b0;
      ack_sent_q <= 1'b0;
      pme_pend_q <= 1'b0;
      msg_req_q <= 1'b0;
      msg_code_q <= MSG_CODE_RST;
    end else begin
      ack_pend_q <= ack_pend_d;
      ack_sent_q <= ack_sent_d;
      pme_pend_q <= pme_pend_d;
      msg_req_q <= msg_req_d;
      msg_code_q <= msg_code_d;
    end
  end

  assign TX_ALLOW = tx_allow_q;
  assign TX_MSG_REQ = msg_req_q;
  assign TX_MSG_CODE = msg_code_q;
  // posted message, routed to the root complex
  assign TX_MSG_ROUTE = MSG_ROUTE_TO_RC;
  assign TX_MSG_POSTED = 1'b1;
  assign PHY_REQ_STATE = phy_req_q;
  assign PWR_STATE_FIELD = pwr_field_q;
  assign D0_ACTIVE = d0_act_q;
  assign NO_SOFT_RESET = nsr_q;
  assign PCI_CLK_RUN = clk_run_q;
  assign PCI_BUS_RESET_OUT_N = bus_rst_n_q;
  assign PCI_XACT_ALLOW = xact_q;

  // no L0s entry with the enable clear
  chk_l0s_disabled: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (link_q == LK_L0 && !CFG_L0S_ENABLE) |=> link_q != LK_L0S)
    else $error("L0s entered with entry disabled");
  // L0s only after the full idle count
  chk_l0s_idle: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (link_q == LK_L0S && $past(link_q) == LK_L0) |-> $past(idle_cnt_q) == IDLE_LIMIT)
    else $error("L0s entered before idle time elapsed");
  chk_l0s_wake: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (link_q == LK_L0S && TX_PENDING) |=> link_q == LK_L0S_EXIT)
    else $error("Pending packet did not start L0s exit");
  chk_tx_gated: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (link_q != LK_L0) |-> (!TX_ALLOW && !TX_MSG_REQ))
    else $error("Transmit allowed outside L0");
  chk_l1_d3only: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (link_q == LK_L1_ENTER && $past(link_q) == LK_L0) |-> $past(dstate_q) == DS_D3HOT)
    else $error("L1 entry without D3hot");
  // D3hot with an idle link enters L1 next
  chk_d3_to_l1: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (link_q == LK_L0 && dstate_q == DS_D3HOT && l1_go_q && !busy && !ack_sent_q)
    |=> link_q == LK_L1_ENTER ##0 PHY_REQ_STATE == PHY_L1)
    else $error("D3hot did not start L1 entry");
  // no-soft-reset set on return to D0
  chk_nsr_set: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    ($past(dstate_q) == DS_D3HOT && dstate_q == DS_D0_UNINIT) |-> NO_SOFT_RESET)
    else $error("No-soft-reset bit not set on D3hot to D0");
  // D1 and D2 writes are dropped
  chk_d12_drop: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (CFG_PWR_WR && (CFG_PWR_DATA == PWR_FIELD_D1 || CFG_PWR_DATA == PWR_FIELD_D2))
    |=> $stable(PWR_STATE_FIELD) && ($stable(dstate_q) || dstate_q == DS_D0_ACTIVE))
    else $error("Unsupported power state accepted");
  // L2/L3 Ready only after the acknowledge went out
  chk_ack_first: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (link_q == LK_L23_ENTER) |-> (ack_sent_q && !TX_MSG_REQ))
    else $error("L2/L3 Ready entry without acknowledge");

endmodule : plpm_top

// File: common/plpm_pkg.sv
// Shared constants, encodings and state types of the link power manager
package plpm_pkg;

  // Core clock period used to turn times into cycle counts
  localparam int CLK_PERIOD_NS = 10;

  // Transmit idle time before L0s entry, rounded up to whole cycles
  localparam int L0S_IDLE_NS = 6000;
  localparam int L0S_IDLE_CYC = (L0S_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CNT_W = 10;

  // Interval between samples of the PCI-side PME input
  localparam int PME_SAMPLE_NS = 100000;
  localparam int PME_SAMPLE_CYC = (PME_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Device power state field encodings
  localparam logic [1:0] PWR_FIELD_D0 = 2'h0;
  localparam logic [1:0] PWR_FIELD_D1 = 2'h1;
  localparam logic [1:0] PWR_FIELD_D2 = 2'h2;
  localparam logic [1:0] PWR_FIELD_D3HOT = 2'h3;
  localparam logic [1:0] PWR_FIELD_RST = PWR_FIELD_D0;

  // Message codes and routing of upstream power management messages
  localparam logic [7:0] MSG_CODE_PME = 8'h18;
  localparam logic [7:0] MSG_CODE_TO_ACK = 8'h1b;
  localparam logic [7:0] MSG_CODE_RST = 8'h00;
  localparam logic [2:0] MSG_ROUTE_TO_RC = 3'h0;

  // Link state requested from, and reported by, the physical layer
  typedef enum logic [2:0] {
    PHY_L0  = 3'b000,
    PHY_L0S = 3'b001,
    PHY_L1  = 3'b010,
    PHY_L23 = 3'b011
  } plpm_phy_t;

  typedef enum logic [1:0] {
    DS_D0_UNINIT = 2'b00,
    DS_D0_ACTIVE = 2'b01,
    DS_D3HOT     = 2'b10
  } plpm_dstate_t;

  typedef enum logic [2:0] {
    LK_L0        = 3'b000,
    LK_L0S       = 3'b001,
    LK_L0S_EXIT  = 3'b010,
    LK_L1_ENTER  = 3'b011,
    LK_L1        = 3'b100,
    LK_L1_EXIT   = 3'b101,
    LK_L23_ENTER = 3'b110,
    LK_L23       = 3'b111
  } plpm_link_t;

endpackage : plpm_pkg

// File: common/plpm_pme_if.sv
// Carrier between the PME sampler and the power manager core
`timescale 1ns/10ps
interface plpm_pme_if;
  logic ignore;
  logic new_pme;
  logic level;
  modport src (input ignore, output new_pme, output level);
  modport snk (output ignore, input new_pme, input level);
endinterface : plpm_pme_if

// File: verilog/plpm_pme_sampler.sv
// Synchroniser and periodic sampler of the PCI-side PME input
`timescale 1ns/10ps
module plpm_pme_sampler
  import plpm_pkg::*;
#(
  parameter int SAMPLE_CYCLES = PME_SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pme_pin_n,
  plpm_pme_if.src pme
);

  localparam int CW = $clog2(SAMPLE_CYCLES);
  localparam logic [CW-1:0] TICK_LAST = CW'(SAMPLE_CYCLES - 1);

  logic sync1_q;
  logic sync2_q;
  logic [CW-1:0] tick_cnt_q;
  logic [CW-1:0] tick_cnt_d;
  logic level_q;
  logic level_d;
  logic new_q;
  logic new_d;
  logic tick;

  always_comb begin
    tick = (tick_cnt_q == TICK_LAST);
    tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
    level_d = level_q;
    new_d = 1'b0;
    if (tick) begin
      if (pme.ignore) begin
        level_d = 1'b0;
      end else begin
        level_d = !sync2_q;
        new_d = !sync2_q && !level_q;
      end
    end
  end

  // Idle pin level is high, so the synchroniser resets to one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      tick_cnt_q <= '0;
      level_q <= 1'b0;
      new_q <= 1'b0;
    end else begin
      sync1_q <= pme_pin_n;
      sync2_q <= sync1_q;
      tick_cnt_q <= tick_cnt_d;
      level_q <= level_d;
      new_q <= new_d;
    end
  end

  assign pme.new_pme = new_q;
  assign pme.level = level_q;

  // event only right after a tick
  chk_pme_on_tick: assert property (
    @(posedge clk) disable iff (rst) new_q |-> $past(tick_cnt_q) == TICK_LAST)
    else $error("PME event outside a sample tick");

  chk_pme_ignored: assert property (
    @(posedge clk) disable iff (rst) (pme.ignore && tick) |=> !new_q)
    else $error("PME event raised while input ignored");

endmodule : plpm_pme_sampler

// File: bench/plpm_link_partner.sv
// Behavioural physical layer and upstream port facing the power manager
`timescale 1ns/10ps
module plpm_link_partner
  import plpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire logic [2:0] req_state,
  input wire logic msg_req,
  output logic [2:0] cur_state,
  output logic msg_done
);
  logic [3:0] st_cnt_q;
  logic [3:0] msg_cnt_q;

  // Latency is set by the bench so both prompt and sluggish links are seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_cnt_q <= 4'h0;
      msg_cnt_q <= 4'h0;
      cur_state <= PHY_L0;
      msg_done <= 1'b0;
    end else begin
      if (cur_state != req_state) begin
        if (st_cnt_q >= lat) begin
          cur_state <= req_state;
          st_cnt_q <= 4'h0;
        end else begin
          st_cnt_q <= st_cnt_q + 4'h1;
        end
      end else begin
        st_cnt_q <= 4'h0;
      end
      msg_done <= 1'b0;
      if (msg_req && !msg_done && cur_state == PHY_L0) begin
        if (msg_cnt_q >= lat) begin
          msg_done <= 1'b1;
          msg_cnt_q <= 4'h0;
        end else begin
          msg_cnt_q <= msg_cnt_q + 4'h1;
        end
      end else begin
        msg_cnt_q <= 4'h0;
      end
    end
  end
endmodule : plpm_link_partner

// File: bench/tb_pcie_link_power_manager.sv
// Self-checking bench of the link power manager
`timescale 1ns/10ps
module tb_pcie_link_power_manager;
  import plpm_pkg::*;
  localparam int SMP = 32;
  logic clk, rst, l0s_en, pwr_wr, mem_en, io_en, bm_en, tx_pend, tx_sent, turn_off, pme_n;
  logic [1:0] pwr_data;
  logic [3:0] lat;
  logic [2:0] phy_cur, phy_req, msg_route;
  logic [7:0] msg_code;
  logic msg_done, tx_allow, msg_req, posted, d0_act, nsr, clk_run, brst_n, xact;
  logic [1:0] field;
  int err_total;
  int num_checks;

  plpm_top #(.PME_SAMPLE_CYCLES(SMP)) i_dut (.CORE_CLK(clk), .RST(rst),
    .CFG_L0S_ENABLE(l0s_en), .CFG_PWR_WR(pwr_wr), .CFG_PWR_DATA(pwr_data),
    .CFG_MEM_EN(mem_en), .CFG_IO_EN(io_en), .CFG_BM_EN(bm_en), .TX_PENDING(tx_pend),
    .TX_SENT(tx_sent), .TX_MSG_DONE(msg_done), .RX_TURN_OFF(turn_off),
    .PHY_CUR_STATE(phy_cur), .PCI_PME_N(pme_n), .TX_ALLOW(tx_allow), .TX_MSG_REQ(msg_req),
    .TX_MSG_CODE(msg_code), .TX_MSG_ROUTE(msg_route), .TX_MSG_POSTED(posted),
    .PHY_REQ_STATE(phy_req), .PWR_STATE_FIELD(field), .D0_ACTIVE(d0_act),
    .NO_SOFT_RESET(nsr), .PCI_CLK_RUN(clk_run), .PCI_BUS_RESET_OUT_N(brst_n),
    .PCI_XACT_ALLOW(xact));

  plpm_link_partner i_phy (.clk(clk), .rst(rst), .lat(lat), .req_state(phy_req),
    .msg_req(msg_req), .cur_state(phy_cur), .msg_done(msg_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] probe(int sel);
    case (sel)
      0: probe = {5'h0, phy_req};
      1: probe = {7'h0, tx_allow};
      2: probe = {7'h0, msg_req};
      3: probe = {7'h0, clk_run};
      default: probe = {5'h0, phy_cur};
    endcase
  endfunction : probe

  // Bounded wait; a bound that runs out ends the run as a failure
  task automatic wait_for(int sel, logic [7:0] v, int lim, output int n);
    n = 0;
    while (n < lim && probe(sel) !== v) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (probe(sel) !== v) begin
      err_total++;
      $display("BAD wait %0d expected %h seen %h", sel, v, probe(sel));
      complete_run();
    end
  endtask : wait_for

  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
  endtask : do_reset

  task automatic pwr_write(logic [1:0] d);
    @(posedge clk);
    pwr_data <= d;
    pwr_wr <= 1'b1;
    @(posedge clk);
    pwr_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : pwr_write

  task automatic t_d0();
    for (int i = 0; i < 3; i++) begin
      do_reset();
      chk("field", 8'h0, field);
      chk("d0_active", 8'h0, d0_act);
      chk("no_soft_rst", 8'h0, nsr);
      chk("bus_rst_n", 8'h1, brst_n);
      @(posedge clk);
      {bm_en, io_en, mem_en} <= 3'h1 << i;
      repeat (2) @(posedge clk);
      #1;
      chk("d0_active", 8'h1, d0_act);
      @(posedge clk);
      {bm_en, io_en, mem_en} <= 3'h0;
    end
    $display("test d0 states done");
  endtask : t_d0

  task automatic t_l0s();
    int n;
    repeat (700) @(posedge clk);
    #1;
    chk("phy_req", 8'h0, phy_req);
    // The idle count is saturated by now, so a sent packet restarts it first
    @(posedge clk);
    tx_sent <= 1'b1;
    @(posedge clk);
    tx_sent <= 1'b0;
    l0s_en <= 1'b1;
    wait_for(0, 8'h1, 700, n);
    chk("idle_span", 8'h1, {7'h0, n > L0S_IDLE_CYC && n <= L0S_IDLE_CYC + 3});
    chk("tx_allow", 8'h0, tx_allow);
    wait_for(4, 8'h1, 20, n);
    @(posedge clk);
    tx_pend <= 1'b1;
    wait_for(1, 8'h1, 40, n);
    chk("phy_req", 8'h0, phy_req);
    @(posedge clk);
    tx_pend <= 1'b0;
    l0s_en <= 1'b0;
    $display("test l0s done");
  endtask : t_l0s

  task automatic t_d3();
    int n;
    lat <= 4'h9;
    pwr_write(2'h3);
    chk("field", 8'h3, field);
    chk("xact", 8'h0, xact);
    wait_for(0, 8'h2, 10, n);
    chk("tx_allow", 8'h0, tx_allow);
    wait_for(4, 8'h2, 30, n);
    chk("clk_run", 8'h1, clk_run);
    chk("bus_rst_n", 8'h1, brst_n);
    for (int d = 1; d < 3; d++) begin
      pwr_write(d[1:0]);
      chk("field", 8'h3, field);
    end
    @(posedge clk);
    pme_n <= 1'b0;
    wait_for(2, 8'h1, 4 * SMP + 20, n);
    chk("link_at_msg", 8'h0, phy_cur);
    chk("msg_code", 8'h18, msg_code);
    chk("msg_route", 8'h0, msg_route);
    chk("posted", 8'h1, posted);
    wait_for(2, 8'h0, 40, n);
    @(posedge clk);
    pme_n <= 1'b1;
    pwr_write(2'h0);
    chk("field", 8'h0, field);
    chk("no_soft_rst", 8'h1, nsr);
    wait_for(1, 8'h1, 60, n);
    @(posedge clk);
    lat <= 4'h2;
    $display("test d3hot done");
  endtask : t_d3

  task automatic t_off();
    int n;
    logic hits;
    hits = 1'b0;
    @(posedge clk);
    turn_off <= 1'b1;
    @(posedge clk);
    turn_off <= 1'b0;
    wait_for(2, 8'h1, 20, n);
    chk("msg_code", 8'h1b, msg_code);
    wait_for(0, 8'h3, 40, n);
    wait_for(3, 8'h0, 40, n);
    chk("bus_rst_n", 8'h0, brst_n);
    chk("tx_allow", 8'h0, tx_allow);
    chk("xact", 8'h0, xact);
    @(posedge clk);
    pme_n <= 1'b0;
    // The link never returns to L0 here, so the sampler's event is watched directly
    repeat (4 * SMP) begin
      @(posedge clk);
      #1;
      hits = hits | i_dut.pme_if.new_pme;
    end
    chk("pme_event", 8'h0, {7'h0, hits});
    chk("pme_ignored", 8'h0, msg_req);
    @(posedge clk);
    pme_n <= 1'b1;
    do_reset();
    chk("field", 8'h0, field);
    chk("no_soft_rst", 8'h0, nsr);
    chk("clk_run", 8'h1, clk_run);
    $display("test turn off done");
  endtask : t_off

  initial begin
    err_total = 0;
    num_checks = 0;
    rst = 1'b1;
    {l0s_en, pwr_wr, mem_en, io_en, bm_en, tx_pend, tx_sent, turn_off} = 8'h0;
    pme_n = 1'b1;
    pwr_data = 2'h0;
    lat = 4'h2;
    t_d0();
    t_l0s();
    t_d3();
    t_off();
    complete_run();
  end
endmodule : tb_pcie_link_power_manager
